// file: logic/i2c_link_sampler.sv
// Link-clock side of the control-port target: samples the data line on each bus clock rise.
// Assumes the bus clock is a clock port; reset arrives from the system domain.
`timescale 1ns/1ps
module i2c_link_sampler (
   input wire logic scl_clock,  // Bus clock from the controller
   input wire logic reset,      // System reset, resynchronised here
   input wire logic sda_in,     // Data line level
   output logic sampled_bit,    // Data level at the last clock rise
   output logic bit_toggle      // Flips once per clock rise
);
   import i2c_target_pkg::*;

   link_state_s s_ff;
   link_state_s nxt_s;

   // Clock may stand still; reset only takes hold after two rises
   always_comb begin
      nxt_s = s_ff;
      nxt_s.rst_sync = {s_ff.rst_sync[0], reset};
      if (s_ff.rst_sync[1]) begin
         nxt_s.bit_val = 1'b0;
         nxt_s.toggle = 1'b0;
      end else begin
         nxt_s.bit_val = sda_in;
         nxt_s.toggle = ~s_ff.toggle;
      end
   end

   always_ff @(posedge scl_clock) begin
      s_ff <= nxt_s;
   end

   assign sampled_bit = s_ff.bit_val;
   assign bit_toggle = s_ff.toggle;
endmodule // i2c_link_sampler

// file: logic/i2c_target_pkg.sv
// Types shared by the serial control-port target and its link-clock sampler.
// Assumes compilation before both design modules.
package i2c_target_pkg;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_ADDR     = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_REG      = 4'h3,
      ST_REG_ACK  = 4'h4,
      ST_WR       = 4'h5,
      ST_WR_ACK   = 4'h6,
      ST_TX       = 4'h7,
      ST_TX_ACK   = 4'h8,
      ST_IGNORE   = 4'h9
   } tgt_state_e;

   typedef struct packed {
      logic [1:0] rst_sync;
      logic bit_val;
      logic toggle;
   } link_state_s;

   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic [1:0] tog_sync;
      logic [1:0] sel_lo_sync;
      logic [1:0] sel_hi_sync;
      logic scl_prev;
      logic sda_prev;
      logic tog_seen;
      tgt_state_e state;
      logic [7:0] shift;
      logic [3:0] bit_cnt;
      logic ack_due;
      logic is_read;
      logic got_upper;
      logic tx_lower;
      logic ctrl_ack;
      logic [7:0] reg_addr;
      logic [7:0] upper_data_byte;
      logic [15:0] tx_data;
      logic sda_oe_n;
      logic sda_level;
      logic wr_valid;
      logic [15:0] wr_data;
      logic busy;
   } tgt_state_s;

endpackage

// file: logic/i2c_target_reg16_access.sv
// Control-port target: address decode, 16-bit register access as byte pairs.
// Assumes a single controller drives the bus clock; the register file answers
// reg_rd_data combinationally for reg_addr on the system clock.
//
// Contract
// - Target only, never starts a transfer.
// - Address in bits 7..1, bit 0 direction.
// - Select pins set address bits 1 and 2.
// - Answer the four pin-selected addresses.
// - Answer the generic address too.
// - Acknowledge address and register address bytes.
// - Registers are two bytes, upper first.
// - Every byte travels most significant bit first.
// - Increment register address between written pairs.
// - Read: repeated start, read address acknowledged.
// - Send upper byte, then lower byte.
// - Controller acknowledge moves to next register.
// - Negative acknowledge releases the data line.
`timescale 1ns/1ps
`include "i2c_target_regs.svh"
module i2c_target_reg16_access (
   input wire logic clock,                 // System clock
   input wire logic reset,                 // Synchronous reset, high
   input wire logic scl_clock,             // Bus clock from controller
   input wire logic sda_in,                // Data line level
   output logic sda_out,                   // Data level when driven, always low
   output logic sda_oe_n,                  // Low while pulling the data line
   input wire logic addr_select_low_pin,   // Address bit 1 strap
   input wire logic addr_select_high_pin,  // Address bit 2 strap
   input wire logic [15:0] reg_rd_data,    // Register contents at reg_addr
   output logic [7:0] reg_addr,            // Current register address
   output logic reg_wr_valid,              // One-cycle write strobe
   output logic [15:0] reg_wr_data,        // Pair written, upper byte high
   output logic busy                       // Between start and stop
);
   import i2c_target_pkg::*;

   localparam int BIT_CYCLES = `TGT_CYCLES_PER_BIT;
   localparam tgt_state_s RST = '{
      scl_sync: 2'h3, sda_sync: 2'h3, tog_sync: 2'h0,
      sel_lo_sync: 2'h0, sel_hi_sync: 2'h0,
      scl_prev: 1'b1, sda_prev: 1'b1, tog_seen: 1'b0,
      state: ST_IDLE, shift: 8'h00, bit_cnt: 4'h0,
      ack_due: 1'b0, is_read: 1'b0, got_upper: 1'b0, tx_lower: 1'b0, ctrl_ack: 1'b0,
      reg_addr: `TGT_REG_ADDR_RST, upper_data_byte: 8'h00, tx_data: `TGT_DATA_RST,
      sda_oe_n: 1'b1, sda_level: 1'b0, wr_valid: 1'b0, wr_data: `TGT_DATA_RST,
      busy: 1'b0
   };

   tgt_state_s s_ff;
   tgt_state_s nxt_s;
   logic rx_bit;
   logic rx_toggle;
   logic scl;
   logic sda;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic bit_evt;
   logic [7:0] rx_byte;
   logic pin_hit;
   logic gen_hit;

   i2c_link_sampler u_link (
      .scl_clock(scl_clock),
      .reset(reset),
      .sda_in(sda_in),
      .sampled_bit(rx_bit),
      .bit_toggle(rx_toggle)
   );

   assign scl = s_ff.scl_sync[1];
   assign sda = s_ff.sda_sync[1];
   assign scl_fall = s_ff.scl_prev & ~scl;
   assign start_seen = scl & s_ff.scl_prev & s_ff.sda_prev & ~sda;
   assign stop_seen = scl & s_ff.scl_prev & ~s_ff.sda_prev & sda;
   // Bit level is held by the link flop for a whole bus clock, so it is
   // stable well before the synchronised toggle announces it
   assign bit_evt = s_ff.tog_sync[1] != s_ff.tog_seen;
   assign rx_byte = {s_ff.shift[6:0], rx_bit};
   assign pin_hit = s_ff.shift[7:1] ==
      {`TGT_PIN_ADDR_PREFIX, s_ff.sel_hi_sync[1], s_ff.sel_lo_sync[1]};
   assign gen_hit = s_ff.shift[7:1] == `TGT_GENERIC_ADDR;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.scl_sync = {s_ff.scl_sync[0], scl_clock};
      nxt_s.sda_sync = {s_ff.sda_sync[0], sda_in};
      nxt_s.tog_sync = {s_ff.tog_sync[0], rx_toggle};
      nxt_s.sel_lo_sync = {s_ff.sel_lo_sync[0], addr_select_low_pin};
      nxt_s.sel_hi_sync = {s_ff.sel_hi_sync[0], addr_select_high_pin};
      nxt_s.scl_prev = scl;
      nxt_s.sda_prev = sda;
      nxt_s.tog_seen = s_ff.tog_sync[1];
      nxt_s.wr_valid = 1'b0;
      if (start_seen) begin
         // Repeated start lands here too, from any state
         nxt_s.state = ST_ADDR;
         nxt_s.bit_cnt = 4'h0;
         nxt_s.ack_due = 1'b0;
         nxt_s.sda_oe_n = 1'b1;
         nxt_s.busy = 1'b1;
      end else if (stop_seen) begin
         nxt_s.state = ST_IDLE;
         nxt_s.sda_oe_n = 1'b1;
         nxt_s.busy = 1'b0;
      end else begin
         unique case (s_ff.state)
            ST_IDLE, ST_IGNORE: begin
               nxt_s.sda_oe_n = 1'b1;
            end
            ST_ADDR, ST_REG, ST_WR: begin
               if (bit_evt && !s_ff.ack_due) begin
                  nxt_s.shift = rx_byte;
                  nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                  if (s_ff.bit_cnt == `TGT_BYTE_LAST_BIT) begin
                     nxt_s.ack_due = 1'b1;
                  end
               end
               if (s_ff.ack_due && scl_fall) begin
                  nxt_s.ack_due = 1'b0;
                  nxt_s.bit_cnt = 4'h0;
                  if (s_ff.state == ST_ADDR) begin
                     if (pin_hit || gen_hit) begin
                        nxt_s.sda_oe_n = 1'b0;
                        nxt_s.is_read = s_ff.shift[0] == `TGT_DIR_READ;
                        nxt_s.state = ST_ADDR_ACK;
                     end else begin
                        nxt_s.state = ST_IGNORE;
                     end
                  end else if (s_ff.state == ST_REG) begin
                     nxt_s.reg_addr = s_ff.shift;
                     nxt_s.sda_oe_n = 1'b0;
                     nxt_s.state = ST_REG_ACK;
                  end else begin
                     nxt_s.sda_oe_n = 1'b0;
                     nxt_s.state = ST_WR_ACK;
                     if (!s_ff.got_upper) begin
                        nxt_s.upper_data_byte = s_ff.shift;
                        nxt_s.got_upper = 1'b1;
                     end else begin
                        nxt_s.wr_valid = 1'b1;
                        nxt_s.wr_data = {s_ff.upper_data_byte, s_ff.shift};
                        nxt_s.got_upper = 1'b0;
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (s_ff.is_read) begin
                     // Whole register captured now so both bytes belong together
                     nxt_s.tx_data = reg_rd_data;
                     nxt_s.sda_oe_n = reg_rd_data[15];
                     nxt_s.shift = {reg_rd_data[14:8], 1'b0};
                     nxt_s.bit_cnt = 4'h0;
                     nxt_s.tx_lower = 1'b0;
                     nxt_s.state = ST_TX;
                  end else begin
                     nxt_s.sda_oe_n = 1'b1;
                     nxt_s.state = ST_REG;
                  end
               end
            end
            ST_REG_ACK: begin
               if (scl_fall) begin
                  nxt_s.sda_oe_n = 1'b1;
                  nxt_s.got_upper = 1'b0;
                  nxt_s.state = ST_WR;
               end
            end
            ST_WR_ACK: begin
               if (s_ff.wr_valid) begin
                  nxt_s.reg_addr = s_ff.reg_addr + 8'h01;
               end
               if (scl_fall) begin
                  nxt_s.sda_oe_n = 1'b1;
                  nxt_s.state = ST_WR;
               end
            end
            ST_TX: begin
               if (bit_evt) begin
                  nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
               end
               if (scl_fall) begin
                  if (s_ff.bit_cnt == `TGT_BYTE_BITS) begin
                     nxt_s.sda_oe_n = 1'b1;
                     nxt_s.bit_cnt = 4'h0;
                     nxt_s.ack_due = 1'b0;
                     nxt_s.state = ST_TX_ACK;
                  end else begin
                     nxt_s.sda_oe_n = s_ff.shift[7];
                     nxt_s.shift = {s_ff.shift[6:0], 1'b0};
                  end
               end
            end
            ST_TX_ACK: begin
               if (bit_evt && !s_ff.ack_due) begin
                  nxt_s.ack_due = 1'b1;
                  nxt_s.ctrl_ack = ~rx_bit;
                  if (!rx_bit && s_ff.tx_lower) begin
                     nxt_s.reg_addr = s_ff.reg_addr + 8'h01;
                  end
               end
               if (s_ff.ack_due && scl_fall) begin
                  nxt_s.ack_due = 1'b0;
                  nxt_s.bit_cnt = 4'h0;
                  if (!s_ff.ctrl_ack) begin
                     nxt_s.sda_oe_n = 1'b1;
                     nxt_s.state = ST_IGNORE;
                  end else if (s_ff.tx_lower) begin
                     nxt_s.tx_data = reg_rd_data;
                     nxt_s.sda_oe_n = reg_rd_data[15];
                     nxt_s.shift = {reg_rd_data[14:8], 1'b0};
                     nxt_s.tx_lower = 1'b0;
                     nxt_s.state = ST_TX;
                  end else begin
                     nxt_s.sda_oe_n = s_ff.tx_data[7];
                     nxt_s.shift = {s_ff.tx_data[6:0], 1'b0};
                     nxt_s.tx_lower = 1'b1;
                     nxt_s.state = ST_TX;
                  end
               end
            end
            default: begin
               nxt_s.state = ST_IGNORE;
               nxt_s.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         s_ff <= RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign sda_out = s_ff.sda_level;
   assign sda_oe_n = s_ff.sda_oe_n;
   assign reg_addr = s_ff.reg_addr;
   assign reg_wr_valid = s_ff.wr_valid;
   assign reg_wr_data = s_ff.wr_data;
   assign busy = s_ff.busy;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_idle_no_drive: assert property (
      !s_ff.busy |-> s_ff.sda_oe_n)
      else $error("data line driven outside a transfer");

   a_start_to_addr: assert property (
      start_seen |=> s_ff.state == ST_ADDR && s_ff.bit_cnt == 4'h0 && s_ff.busy)
      else $error("start did not restart address reception");

   a_pin_addr_ack: assert property (
      (s_ff.state == ST_ADDR && s_ff.ack_due && scl_fall && !start_seen && !stop_seen
       && s_ff.shift[7:3] == `TGT_PIN_ADDR_PREFIX
       && s_ff.shift[2] == s_ff.sel_hi_sync[1] && s_ff.shift[1] == s_ff.sel_lo_sync[1])
      |=> !s_ff.sda_oe_n && s_ff.state == ST_ADDR_ACK)
      else $error("pin-selected address not acknowledged");

   a_generic_ack: assert property (
      (s_ff.state == ST_ADDR && s_ff.ack_due && scl_fall && !start_seen && !stop_seen
       && s_ff.shift[7:1] == `TGT_GENERIC_ADDR)
      |=> !s_ff.sda_oe_n && s_ff.is_read == $past(s_ff.shift[0]))
      else $error("generic address not acknowledged");

   a_reg_addr_ack: assert property (
      (s_ff.state == ST_REG && s_ff.ack_due && scl_fall && !start_seen && !stop_seen)
      |=> !s_ff.sda_oe_n && s_ff.reg_addr == $past(s_ff.shift))
      else $error("register address byte not taken and acknowledged");

   a_pair_order: assert property (
      s_ff.wr_valid |-> s_ff.wr_data[15:8] == s_ff.upper_data_byte && !s_ff.got_upper)
      else $error("written pair not upper byte first");

   a_rx_msb_first: assert property (
      (bit_evt && !s_ff.ack_due && s_ff.state == ST_REG && !start_seen && !stop_seen)
      |=> s_ff.shift[0] == $past(rx_bit) && s_ff.shift[7:1] == $past(s_ff.shift[6:0]))
      else $error("received bit not shifted in at the bottom");

   a_write_incr: assert property (
      s_ff.wr_valid && !start_seen && !stop_seen
      |=> s_ff.reg_addr == $past(s_ff.reg_addr) + 8'h01)
      else $error("register address not advanced after a pair");

   a_read_upper_first: assert property (
      (s_ff.state == ST_ADDR_ACK && s_ff.is_read && scl_fall && !start_seen && !stop_seen)
      |=> s_ff.sda_oe_n == $past(reg_rd_data[15]) && s_ff.state == ST_TX)
      else $error("read did not begin with the upper byte");

   a_read_incr: assert property (
      (s_ff.state == ST_TX_ACK && bit_evt && !s_ff.ack_due && !rx_bit && s_ff.tx_lower
       && !start_seen && !stop_seen)
      |=> s_ff.reg_addr == $past(s_ff.reg_addr) + 8'h01)
      else $error("register address not advanced after acknowledged lower byte");

   a_nack_release: assert property (
      (s_ff.state == ST_TX_ACK && s_ff.ack_due && !s_ff.ctrl_ack && scl_fall
       && !start_seen && !stop_seen)
      |=> s_ff.sda_oe_n [*3])
      else $error("data line not released after negative acknowledge");

   a_foreign_silent: assert property (
      s_ff.state == ST_IGNORE |-> s_ff.sda_oe_n)
      else $error("data line driven for a foreign address");

   c_pair_written: cover property (s_ff.wr_valid ##[1:1000] s_ff.wr_valid);
   c_read_two_regs: cover property (
      s_ff.state == ST_TX && s_ff.tx_lower ##[1:1000] s_ff.state == ST_TX && !s_ff.tx_lower);
   c_read_nack: cover property (s_ff.state == ST_TX_ACK ##1 s_ff.state == ST_IGNORE);
   c_bit_spacing: cover property (bit_evt ##[BIT_CYCLES:500] bit_evt);
endmodule // i2c_target_reg16_access

// file: logic/i2c_target_regs.svh
// Constants for the serial control-port target: address codes, reset values, timing.
// Assumes inclusion by bare name from the design files of this block.
`ifndef I2C_TARGET_REGS_SVH
`define I2C_TARGET_REGS_SVH
`define TGT_PIN_ADDR_PREFIX 5'h0D
`define TGT_GENERIC_ADDR 7'h0E
`define TGT_DIR_READ 1'h1
`define TGT_BYTE_LAST_BIT 4'h7
`define TGT_BYTE_BITS 4'h8
`define TGT_REG_ADDR_RST 8'h00
`define TGT_DATA_RST 16'h0000
`define TGT_BUS_MAX_KHZ 400
`define TGT_SYS_CLK_KHZ 10000
`define TGT_CYCLES_PER_BIT (`TGT_SYS_CLK_KHZ / `TGT_BUS_MAX_KHZ)
`endif

// file: verif/i2c_host_model.sv
// Behavioural bus controller: drives the bus clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module i2c_host_model #(
   parameter int QTR = 626  // Quarter bit time, about 400 kHz
) (
   output logic scl,      // Bus clock, idles high
   output logic sda_low,  // High while pulling data low
   input wire logic sda   // Resolved data line
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Short pulses with the data line idle, so link-side flops enter and leave reset
   task automatic pulse_link(input int n);
      repeat (n) begin
         #32 scl = 1'b0;
         #32 scl = 1'b1;
      end
   endtask
   // Data falls while the clock is high, also as repeated start
   task automatic start_c();
      #QTR sda_low = 1'b0;
      #QTR scl = 1'b1;
      #QTR sda_low = 1'b1;
      #QTR scl = 1'b0;
   endtask
   task automatic stop_c();
      #QTR sda_low = 1'b1;
      #QTR scl = 1'b1;
      #QTR sda_low = 1'b0;
      #(2 * QTR);
   endtask
   task automatic bit_out(input logic b);
      #QTR sda_low = !b;
      #QTR scl = 1'b1;
      #(2 * QTR) scl = 1'b0;
   endtask
   // Released line floats to the pull-up level
   task automatic bit_in(output logic b);
      #QTR sda_low = 1'b0;
      #QTR scl = 1'b1;
      #QTR b = sda;
      #QTR scl = 1'b0;
   endtask
   // Most significant bit first
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(v[i]);
      bit_in(b);
      ack = !b;
   endtask
   // Byte acknowledged unless nack is set, nack ends the read
   task automatic recv_byte(input logic nack, output logic [7:0] v);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_in(b);
         v[i] = b;
      end
      bit_out(nack);
   endtask
endmodule // i2c_host_model

// file: verif/tb.sv
// Self-checking bench for the control-port target with a modelled bus controller.
// Assumes a pull-up on the data line and a register file answering at once.
`timescale 1ns/1ps
module tb;
   logic clock, reset, scl_clock, host_low, sda_wire, sel_lo, sel_hi;
   logic sda_out, sda_oe_n, reg_wr_valid, busy;
   logic [15:0] reg_rd_data, reg_wr_data;
   logic [7:0] reg_addr;
   logic [15:0] regs [256];
   logic [23:0] wr_q [$];
   int n_fail, checks;

   assign sda_wire = host_low ? 1'b0 : (sda_oe_n == 1'b0 ? sda_out : 1'b1);
   assign reg_rd_data = regs[reg_addr];

   i2c_target_reg16_access dut (
      .clock(clock), .reset(reset), .scl_clock(scl_clock), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_low_pin(sel_lo),
      .addr_select_high_pin(sel_hi), .reg_rd_data(reg_rd_data), .reg_addr(reg_addr),
      .reg_wr_valid(reg_wr_valid), .reg_wr_data(reg_wr_data), .busy(busy)
   );
   i2c_host_model host (.scl(scl_clock), .sda_low(host_low), .sda(sda_wire));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      if (reg_wr_valid === 1'b1) begin
         regs[reg_addr] <= reg_wr_data;
         wr_q.push_back({reg_addr, reg_wr_data});
      end
   end

   task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic end_sim();
      if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tx(input logic [7:0] v, input logic e);
      logic a;
      host.send_byte(v, a);
      chk("ack", 24'(e), 24'(a));
   endtask
   task automatic rx(input logic nack, input logic [7:0] e);
      logic [7:0] v;
      host.recv_byte(nack, v);
      chk("read byte", 24'(e), 24'(v));
   endtask
   task automatic set_sel(input logic [1:0] s);
      @(negedge clock);
      sel_hi = s[1];
      sel_lo = s[0];
      repeat (6) @(negedge clock);
   endtask

   task automatic sc_reset();
      chk("oe_n", 24'h1, 24'(sda_oe_n));
      chk("busy", 24'h0, 24'(busy));
      chk("reg_addr", 24'h0, 24'(reg_addr));
      chk("wr_valid", 24'h0, 24'(reg_wr_valid));
   endtask

   // Two pairs at one device address, MSB byte first
   task automatic sc_write(input logic [7:0] dev, input logic [7:0] ra);
      logic [15:0] d0, d1;
      d0 = {8'hD2, ra};
      d1 = {8'h4B, ~ra};
      wr_q.delete();
      host.start_c();
      tx(dev, 1'b1);
      chk("busy", 24'h1, 24'(busy));
      tx(ra, 1'b1);
      tx(d0[15:8], 1'b1);
      tx(d0[7:0], 1'b1);
      tx(d1[15:8], 1'b1);
      tx(d1[7:0], 1'b1);
      host.stop_c();
      chk("writes", 24'h2, 24'(wr_q.size()));
      chk("pair 1", {ra, d0}, wr_q[0]);
      chk("pair 2", {ra + 8'h01, d1}, wr_q[1]);
      chk("next addr", 24'(8'(ra + 8'h02)), 24'(reg_addr));
      chk("busy", 24'h0, 24'(busy));
   endtask

   // Foreign address, then an odd data byte that never stores
   task automatic sc_foreign();
      wr_q.delete();
      host.start_c();
      tx(8'h68, 1'b0);
      tx(8'h20, 1'b0);
      tx(8'hD2, 1'b0);
      tx(8'h4B, 1'b0);
      host.stop_c();
      chk("foreign writes", 24'h0, 24'(wr_q.size()));
      host.start_c();
      tx(8'h6A, 1'b1);
      tx(8'h20, 1'b1);
      tx(8'hD2, 1'b1);
      host.stop_c();
      chk("odd writes", 24'h0, 24'(wr_q.size()));
   endtask

   // Read two registers through the generic address, nack on the last
   task automatic sc_read();
      regs[8'h40] = 16'hA55A;
      regs[8'h41] = 16'h3C96;
      host.start_c();
      tx(8'h1C, 1'b1);
      tx(8'h40, 1'b1);
      host.start_c();
      tx(8'h1D, 1'b1);
      rx(1'b0, 8'hA5);
      rx(1'b0, 8'h5A);
      rx(1'b0, 8'h3C);
      rx(1'b1, 8'h96);
      repeat (8) @(negedge clock);
      chk("released", 24'h1, 24'(sda_oe_n));
      chk("read addr", 24'h41, 24'(reg_addr));
      host.stop_c();
      chk("busy", 24'h0, 24'(busy));
   endtask

   // Hang guard
   initial begin
      repeat (90000) @(posedge clock);
      n_fail++;
      end_sim();
   end

   initial begin
      reset = 1'b1;
      sel_lo = 1'b0;
      sel_hi = 1'b0;
      n_fail = 0;
      checks = 0;
      foreach (regs[i]) regs[i] = 16'h0000;
      fork
         host.pulse_link(3);
         repeat (3) @(posedge clock);
      join
      @(negedge clock);
      reset = 1'b0;
      // Link flops leave reset two bus clock rises late; flush them with the line idle
      host.pulse_link(3);
      repeat (6) @(negedge clock);
      sc_reset();
      for (int s = 0; s < 4; s++) begin
         set_sel(2'(s));
         sc_write({5'b01101, 2'(s), 1'b0}, 8'h10 + 8'(s));
      end
      set_sel(2'b01);
      sc_write(8'h1C, 8'hFF);
      sc_foreign();
      sc_read();
      end_sim();
   end
endmodule // tb
